//--- inc/emgp_map.svh
// register offsets, field positions and timing counts of the ethernet
// management, pause and address-filter block; included by the package and rtl.
// assumes byte addresses on a 32-bit AXI4-Lite bus, one word per register.
//
// Notes on behaviour
// - operation 10 reads the phy; 01 and every other value run a write frame.
// - turnaround field is written as 10 and reads back exactly as written.
// - after a phy read the data field holds the value the phy returned.
// - the register index field goes out as the phy register address.
// - pause register shows the remaining count, decremented every 512 bit times.
// - lower hash register holds bits 31:0 of the 64-bit hash table, read-write.
// - upper hash register holds bits 63:32 of the hash table, read-write.
// - four lower/upper pairs hold destination addresses to match.
// - bit 0 of each lower word is the multicast/unicast indicator.
// - stored bit 0 compares with the lsb of the first received byte.
// - management-done flag sets when a frame completes, clears on status read.
// - pause-expired flag sets when the pause count reaches zero, clears on read.
// - type-match value is compared with the received type/length field.
`ifndef EMGP_MAP_SVH
`define EMGP_MAP_SVH

`define EMGP_OFS_STATUS   8'h24
`define EMGP_OFS_MASK     8'h2C
`define EMGP_OFS_MAN      8'h34
`define EMGP_OFS_PAUSE    8'h38
`define EMGP_OFS_HASH_LO  8'h90
`define EMGP_OFS_HASH_HI  8'h94
`define EMGP_OFS_SA_BASE  8'h98
`define EMGP_OFS_SA_LAST  8'hB4
`define EMGP_OFS_TYPE_MATCH 8'hB8

`define EMGP_ST_MDONE     0
`define EMGP_ST_PEXP      13

`define EMGP_OP_READ      2'h2
`define EMGP_TA_LAST      17
`define EMGP_OP_MSB       29
`define EMGP_OP_LSB       28
`define EMGP_DATA_BITS    16

`define EMGP_PAUSE_BIT_TIMES 512
`define EMGP_CLK_NS          10
`define EMGP_MDC_PERIOD_NS   400

`define EMGP_RESP_OKAY    2'h0
`define EMGP_RESP_SLVERR  2'h2

`define EMGP_TYPE_HI_BYTE 12
`define EMGP_TYPE_LO_BYTE 13
`define EMGP_DA_BYTES     6

`endif

//--- inc/emgp_pkg.sv
// types of the ethernet management, pause and address-filter block.
// assumes emgp_map.svh on the include path.
`include "emgp_map.svh"

package emgp_pkg;

  typedef enum logic {EMGP_IDLE, EMGP_SHIFT} emgp_mstate_type;

  typedef struct packed {
    // register bus
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    // registers
    logic [31:0]      man;
    logic [15:0]      pause;
    logic [63:0]      hash;
    logic [3:0][31:0] sa_lo;
    logic [3:0][15:0] sa_hi;
    logic [15:0]      type_length_match_value;
    logic             mgmt_done_flag;
    logic             pause_expired_flag;
    logic             mask_mdone;
    logic             mask_pexp;
    logic             irq;
    // management link
    emgp_mstate_type  mstate;
    logic [31:0]      shreg;
    logic [4:0]       bit_idx;
    logic [7:0]       div_cnt;
    logic             is_read;
    logic             mdc;
    logic             mdio_out;
    logic             mdio_oe;
    logic [1:0]       mdio_sync;
    // bit clock sampling and pause
    logic [1:0]       bit_sync;
    logic             bit_prev;
    logic [8:0]       bit_cnt;
    // receive filter
    logic [3:0]       byte_cnt;
    logic [47:0]      da;
    logic [15:0]      ltype;
    logic [3:0]       sa_match;
    logic             hash_match;
    logic             type_match;
    logic             match_valid;
  } emgp_state_type;

endpackage : emgp_pkg

//--- rtl/emgp_top.sv
// ethernet mac slice: phy management frame engine, pause countdown and
// destination/type address filter, with AXI4-Lite register access.
// assumes rx bytes come from logic on aclk; bit_clk and mdio_in are asynchronous.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "emgp_map.svh"

module emgp_top #(
  parameter int MDC_HALF = (`EMGP_MDC_PERIOD_NS / 2 + `EMGP_CLK_NS - 1) / `EMGP_CLK_NS
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // interrupt
  output logic             irq,
  // management link
  output logic             mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  // line bit clock, one rising edge per bit time
  input  wire logic        bit_clk,
  // receive byte stream
  input  wire logic        rx_valid,
  input  wire logic        rx_sof,
  input  wire logic [7:0]  rx_data,
  // filter results
  output logic [3:0]       sa_match,
  output logic             hash_match,
  output logic             type_match,
  output logic             match_valid
);

  emgp_pkg::emgp_state_type st;
  emgp_pkg::emgp_state_type next_st;

  // helper strobes, also watched by the assertions
  logic        rd_fire;
  logic        rd_status;
  logic        wr_fire;
  logic        wr_pause;
  logic        mdone_evt;
  logic        pexp_evt;
  logic        bit_edge;
  logic [31:0] wmerged;
  logic [7:0]  sa_rel;
  logic [3:0]  rx_idx;
  logic [5:0]  hash_idx;

  function automatic logic [31:0] emgp_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[b*8 +: 8] = wd[b*8 +: 8];
    end
    return res;
  endfunction : emgp_merge

  always_comb
  begin
    next_st     = st;
    rd_fire     = 1'b0;
    rd_status   = 1'b0;
    wr_fire     = 1'b0;
    wr_pause    = 1'b0;
    mdone_evt   = 1'b0;
    pexp_evt    = 1'b0;
    wmerged     = 32'h0;
    sa_rel      = 8'h0;
    rx_idx      = 4'h0;
    hash_idx    = 6'h0;
    next_st.match_valid = 1'b0;

    // asynchronous inputs: first stage feeds only the second
    next_st.bit_sync  = {st.bit_sync[0], bit_clk};
    next_st.bit_prev  = st.bit_sync[1];
    next_st.mdio_sync = {st.mdio_sync[0], mdio_in};
    bit_edge          = st.bit_sync[1] & ~st.bit_prev;

    // read channel; status clears here, events below win over the clear
    if (arvalid && st.arready)
    begin
      rd_fire         = 1'b1;
      next_st.rvalid  = 1'b1;
      next_st.rresp   = `EMGP_RESP_OKAY;
      next_st.rdata   = 32'h0;
      sa_rel          = araddr - `EMGP_OFS_SA_BASE;
      if (araddr == `EMGP_OFS_STATUS)
      begin
        rd_status = 1'b1;
        next_st.rdata[`EMGP_ST_MDONE] = st.mgmt_done_flag;
        next_st.rdata[`EMGP_ST_PEXP]  = st.pause_expired_flag;
        next_st.mgmt_done_flag     = 1'b0;
        next_st.pause_expired_flag = 1'b0;
      end
      else if (araddr == `EMGP_OFS_MASK)
      begin
        next_st.rdata[`EMGP_ST_MDONE] = st.mask_mdone;
        next_st.rdata[`EMGP_ST_PEXP]  = st.mask_pexp;
      end
      else if (araddr == `EMGP_OFS_MAN)
        next_st.rdata = st.man;
      else if (araddr == `EMGP_OFS_PAUSE)
        next_st.rdata = {16'h0, st.pause};
      else if (araddr == `EMGP_OFS_HASH_LO)
        next_st.rdata = st.hash[31:0];
      else if (araddr == `EMGP_OFS_HASH_HI)
        next_st.rdata = st.hash[63:32];
      else if (araddr >= `EMGP_OFS_SA_BASE && araddr <= `EMGP_OFS_SA_LAST && araddr[1:0] == 2'h0)
        next_st.rdata = sa_rel[2] ? {16'h0, st.sa_hi[sa_rel[4:3]]}
                                  : st.sa_lo[sa_rel[4:3]];
      else if (araddr == `EMGP_OFS_TYPE_MATCH)
        next_st.rdata = {16'h0, st.type_length_match_value};
      else
        next_st.rresp = `EMGP_RESP_SLVERR;
    end
    if (st.rvalid && rready)
      next_st.rvalid = 1'b0;

    // pause countdown on bit-time edges
    if (bit_edge && st.pause != 16'h0)
    begin
      if (st.bit_cnt == 9'(`EMGP_PAUSE_BIT_TIMES - 1))
      begin
        next_st.bit_cnt = 9'h0;
        next_st.pause   = st.pause - 16'h1;
        if (st.pause == 16'h1)
          pexp_evt = 1'b1;
      end
      else
        next_st.bit_cnt = st.bit_cnt + 9'h1;
    end
    if (pexp_evt)
      next_st.pause_expired_flag = 1'b1;

    // management frame engine: change on mdc fall, sample on mdc rise
    case (st.mstate)
      emgp_pkg::EMGP_IDLE:
      begin
        next_st.mdc     = 1'b0;
        next_st.mdio_oe = 1'b0;
      end
      emgp_pkg::EMGP_SHIFT:
      begin
        if (st.div_cnt == 8'(MDC_HALF - 1))
        begin
          next_st.div_cnt = 8'h0;
          next_st.mdc     = ~st.mdc;
          if (!st.mdc)
          begin
            if (st.is_read && st.bit_idx < 5'(`EMGP_DATA_BITS))
              next_st.shreg[st.bit_idx] = st.mdio_sync[1];
          end
          else if (st.bit_idx == 5'h0)
          begin
            next_st.mstate  = emgp_pkg::EMGP_IDLE;
            next_st.mdio_oe = 1'b0;
            mdone_evt       = 1'b1;
            if (st.is_read)
              next_st.man[15:0] = st.shreg[15:0];
          end
          else
          begin
            next_st.bit_idx  = st.bit_idx - 5'h1;
            next_st.mdio_out = st.shreg[st.bit_idx - 5'h1];
            // a read hands the line to the phy from the turnaround on
            next_st.mdio_oe  = !(st.is_read && (st.bit_idx - 5'h1) <= 5'(`EMGP_TA_LAST));
          end
        end
        else
          next_st.div_cnt = st.div_cnt + 8'h1;
      end
      default:
        next_st.mstate = emgp_pkg::EMGP_IDLE;
    endcase
    if (mdone_evt)
      next_st.mgmt_done_flag = 1'b1;

    // receive filter; byte 0 lsb lands in da bit 0
    if (rx_valid)
    begin
      rx_idx           = rx_sof ? 4'h0 : st.byte_cnt;
      next_st.byte_cnt = (rx_idx == 4'hF) ? 4'hF : rx_idx + 4'h1;
      for (int k = 0; k < `EMGP_DA_BYTES; k++)
      begin
        if (rx_idx == 4'(k))
          next_st.da[k*8 +: 8] = rx_data;
      end
      if (rx_idx == 4'(`EMGP_TYPE_HI_BYTE))
        next_st.ltype[15:8] = rx_data;
      if (rx_idx == 4'(`EMGP_TYPE_LO_BYTE))
      begin
        next_st.ltype[7:0] = rx_data;
        for (int i = 0; i < 6; i++)
        begin
          for (int j = 0; j < 8; j++)
            hash_idx[i] = hash_idx[i] ^ st.da[i + 6*j];
        end
        for (int k = 0; k < 4; k++)
          next_st.sa_match[k] = ({st.sa_hi[k], st.sa_lo[k]} == st.da);
        next_st.hash_match  = st.hash[hash_idx];
        next_st.type_match  = ({st.ltype[15:8], rx_data} == st.type_length_match_value);
        next_st.match_valid = 1'b1;
      end
    end

    // write channel: address and data in either order
    if (awvalid && st.awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = awaddr;
    end
    if (wvalid && st.wready)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    if (st.aw_got && st.w_got && !st.bvalid)
    begin
      wr_fire        = 1'b1;
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `EMGP_RESP_OKAY;
      sa_rel         = st.awaddr - `EMGP_OFS_SA_BASE;
      if (st.awaddr == `EMGP_OFS_STATUS)
        next_st.bresp = `EMGP_RESP_OKAY;
      else if (st.awaddr == `EMGP_OFS_MASK)
      begin
        wmerged                 = 32'h0;
        wmerged[`EMGP_ST_MDONE] = st.mask_mdone;
        wmerged[`EMGP_ST_PEXP]  = st.mask_pexp;
        wmerged                 = emgp_merge(wmerged, st.wdata, st.wstrb);
        next_st.mask_mdone = wmerged[`EMGP_ST_MDONE];
        next_st.mask_pexp  = wmerged[`EMGP_ST_PEXP];
      end
      else if (st.awaddr == `EMGP_OFS_MAN)
      begin
        // a write during a frame in flight is dropped to keep the frame whole
        if (st.mstate == emgp_pkg::EMGP_IDLE)
        begin
          wmerged          = emgp_merge(st.man, st.wdata, st.wstrb);
          next_st.man      = wmerged;
          next_st.shreg    = wmerged;
          next_st.is_read  = (wmerged[`EMGP_OP_MSB:`EMGP_OP_LSB] == `EMGP_OP_READ);
          next_st.mstate   = emgp_pkg::EMGP_SHIFT;
          next_st.bit_idx  = 5'h1F;
          next_st.div_cnt  = 8'h0;
          next_st.mdc      = 1'b0;
          next_st.mdio_out = wmerged[31];
          next_st.mdio_oe  = 1'b1;
        end
      end
      else if (st.awaddr == `EMGP_OFS_PAUSE)
      begin
        wr_pause        = 1'b1;
        wmerged         = emgp_merge({16'h0, st.pause}, st.wdata, st.wstrb);
        next_st.pause   = wmerged[15:0];
        next_st.bit_cnt = 9'h0;
      end
      else if (st.awaddr == `EMGP_OFS_HASH_LO)
        next_st.hash[31:0] = emgp_merge(st.hash[31:0], st.wdata, st.wstrb);
      else if (st.awaddr == `EMGP_OFS_HASH_HI)
        next_st.hash[63:32] = emgp_merge(st.hash[63:32], st.wdata, st.wstrb);
      else if (st.awaddr >= `EMGP_OFS_SA_BASE && st.awaddr <= `EMGP_OFS_SA_LAST
               && st.awaddr[1:0] == 2'h0)
      begin
        if (sa_rel[2])
        begin
          wmerged = emgp_merge({16'h0, st.sa_hi[sa_rel[4:3]]}, st.wdata, st.wstrb);
          next_st.sa_hi[sa_rel[4:3]] = wmerged[15:0];
        end
        else
          next_st.sa_lo[sa_rel[4:3]] = emgp_merge(st.sa_lo[sa_rel[4:3]], st.wdata, st.wstrb);
      end
      else if (st.awaddr == `EMGP_OFS_TYPE_MATCH)
      begin
        wmerged                         = emgp_merge({16'h0, st.type_length_match_value},
                                                     st.wdata, st.wstrb);
        next_st.type_length_match_value = wmerged[15:0];
      end
      else
        next_st.bresp = `EMGP_RESP_SLVERR;
    end
    if (st.bvalid && bready)
      next_st.bvalid = 1'b0;

    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
    next_st.irq     = (next_st.mgmt_done_flag && next_st.mask_mdone)
                   || (next_st.pause_expired_flag && next_st.mask_pexp);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign awready     = st.awready;
  assign wready      = st.wready;
  assign bvalid      = st.bvalid;
  assign bresp       = st.bresp;
  assign arready     = st.arready;
  assign rvalid      = st.rvalid;
  assign rresp       = st.rresp;
  assign rdata       = st.rdata;
  assign irq         = st.irq;
  assign mdc         = st.mdc;
  assign mdio_out    = st.mdio_out;
  assign mdio_oe     = st.mdio_oe;
  assign sa_match    = st.sa_match;
  assign hash_match  = st.hash_match;
  assign type_match  = st.type_match;
  assign match_valid = st.match_valid;

  pause_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ce) && !$past(wr_pause) && st.pause != $past(st.pause)
    |-> st.pause == $past(st.pause) - 16'h1
        && $past(st.bit_cnt) == 9'(`EMGP_PAUSE_BIT_TIMES - 1))
    else $error("pause count moved outside a 512 bit-time step");

  pause_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && pexp_evt ##1 1'b1 |-> st.pause == 16'h0 && st.pause_expired_flag)
    else $error("pause reached zero without expired flag");

  mdone_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st.mstate == emgp_pkg::EMGP_SHIFT ##1 st.mstate == emgp_pkg::EMGP_IDLE
    |-> st.mgmt_done_flag)
    else $error("frame ended without done flag");

  status_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && rd_status && !mdone_evt && !pexp_evt
    |=> !st.mgmt_done_flag && !st.pause_expired_flag)
    else $error("status read did not clear flags");

  tx_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st.mstate == emgp_pkg::EMGP_SHIFT && st.mdio_oe
    |-> st.mdio_out == st.shreg[st.bit_idx])
    else $error("management bit out of order");

  read_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st.mstate == emgp_pkg::EMGP_SHIFT && st.is_read && st.bit_idx <= 5'(`EMGP_TA_LAST)
    |-> !st.mdio_oe)
    else $error("line driven during read turnaround or data");

  read_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && mdone_evt && st.is_read |=> st.man[15:0] == $past(st.shreg[15:0]))
    else $error("read data not stored in frame register");

  sa_cmp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && rx_valid && !rx_sof && st.byte_cnt == 4'hD
    |=> st.match_valid && st.sa_match[0] == ({st.sa_hi[0], st.sa_lo[0]} == st.da))
    else $error("address match result wrong");

  type_cmp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st.match_valid |-> st.type_match == (st.ltype == st.type_length_match_value))
    else $error("type match result wrong");

endmodule : emgp_top
`default_nettype wire

//--- verification/emgp_phy_model.sv
// behavioural phy on the far side of the management link.
// assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/10ps
`default_nettype none

module emgp_phy_model (
  // management link
  input  wire logic        mdc,
  input  wire logic        mdio_out,
  input  wire logic        mdio_oe,
  // phy side
  input  wire logic [15:0] rd_data,
  output logic             phy_oe,
  output logic             phy_out,
  output logic [31:0]      got_frame
);
  int          n;
  logic        is_rd;
  logic [31:0] sh;

  initial
  begin
    n         = 0;
    is_rd     = 1'b0;
    sh        = 32'h0;
    phy_oe    = 1'b0;
    phy_out   = 1'b1;
    got_frame = 32'h0;
  end

  always @(posedge mdio_oe) n = 0;

  // sample on the rising clock, msb first
  always @(posedge mdc)
  begin
    sh = {sh[30:0], mdio_out};
    n  = n + 1;
    if (n == 4) is_rd = (sh[1:0] == 2'h2);
    if (n == 32) got_frame = sh;
  end

  // answer a read on the falling clock: turnaround low, then data msb first
  always @(negedge mdc)
  begin
    if (is_rd && n >= 15 && n < 32)
    begin
      phy_oe  = 1'b1;
      phy_out = (n == 15) ? 1'b0 : rd_data[31 - n];
    end
    else
    begin
      phy_oe  = 1'b0;
      phy_out = ~phy_out;
    end
  end
endmodule : emgp_phy_model

`default_nettype wire

//--- verification/test_emgp_top.sv
// self-checking bench: AXI4-Lite register access, management frames,
// pause countdown and receive filter. assumes emgp_map.svh on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "emgp_map.svh"

module test_emgp_top;
  localparam int HALF = 4;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, bit_clk = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rx_data = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF, sa_match;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic        rready = 1'b0, rx_valid = 1'b0, rx_sof = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, mdc, mdio_out, mdio_oe;
  logic        hash_match, type_match, match_valid, phy_oe, phy_out;
  logic [1:0]  bresp, rresp;
  logic [15:0] phy_data = 16'h0;
  logic [31:0] got_frame;
  wire         mdio_in;
  int          n_errors = 0, checks_done = 0;

  always #5 aclk = ~aclk;
  // line bit clock runs free, unrelated to aclk
  always #80 bit_clk = ~bit_clk;
  // pull-up holds the line high when nobody drives it
  assign mdio_in = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);

  emgp_top #(.MDC_HALF(HALF)) dut_u (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .irq, .mdc, .mdio_in, .mdio_out,
    .mdio_oe, .bit_clk, .rx_valid, .rx_sof, .rx_data, .sa_match, .hash_match,
    .type_match, .match_valid);

  emgp_phy_model phy_u (.mdc, .mdio_out, .mdio_oe, .rd_data(phy_data), .phy_oe,
    .phy_out, .got_frame);

  task automatic results;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic tmo;
    n_errors++;
    results();
  endtask : tmo

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) tmo();
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) tmo();
  endtask : axr

  // sel 0 waits for irq, any other value for match_valid
  task automatic wsig(input int sel, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while ((sel == 0 ? irq : match_valid) !== 1'b1 && n < lim);
    if (n >= lim) tmo();
  endtask : wsig

  task automatic t_regs;
    logic [31:0] d, m, rd;
    logic [1:0]  r;
    logic [7:0]  a;
    for (int i = 0; i < 11; i++)
    begin
      a = `EMGP_OFS_HASH_LO + 8'(4 * i);
      m = (i == 10 || (i > 2 && i % 2 == 1)) ? 32'h0000FFFF : 32'hFFFFFFFF;
      d = 32'hC3A55A3C ^ (32'(i) * 32'h01010101);
      axr(a, rd, r);
      chk(rd, 32'h0);
      axw(a, d, r);
      axr(a, rd, r);
      chk(rd, d & m);
    end
    axw(8'hC0, 32'hFFFFFFFF, r);
    chk(32'(r), 32'(`EMGP_RESP_SLVERR));
    axr(8'hC0, rd, r);
    chk({rd[29:0], r}, 32'(`EMGP_RESP_SLVERR));
    // only byte 0 enabled: the other bytes keep the first loop value
    wstrb <= 4'h1;
    axw(`EMGP_OFS_HASH_LO, 32'h0, r);
    wstrb <= 4'hF;
    axr(`EMGP_OFS_HASH_LO, rd, r);
    chk(rd, 32'hC3A55A00);
  endtask : t_regs

  task automatic t_mwrite;
    logic [31:0] f, rd;
    logic [1:0]  r;
    int          n;
    f = {2'h1, 2'h1, 5'h15, 5'h0B, 2'h2, 16'hBEEF};
    axw(`EMGP_OFS_MASK, 32'h1, r);
    axw(`EMGP_OFS_MAN, f, r);
    wsig(0, 600, n);
    chk(got_frame, f);
    chk(32'(n > 16 * 2 * HALF * 2 - 10 && n < 64 * HALF + 10), 32'h1);
    axr(`EMGP_OFS_STATUS, rd, r);
    chk(rd, 32'h1 << `EMGP_ST_MDONE);
    axr(`EMGP_OFS_STATUS, rd, r);
    chk(rd, 32'h0);
    repeat (2) @(posedge aclk);
    chk({30'h0, irq, mdio_oe}, 32'h0);
  endtask : t_mwrite

  task automatic t_mread;
    logic [31:0] f, rd;
    logic [1:0]  r;
    f = {2'h1, 2'h2, 5'h03, 5'h02, 2'h2, 16'h0000};
    phy_data <= 16'h5A3C;
    axw(`EMGP_OFS_MASK, 32'h0, r);
    axw(`EMGP_OFS_MAN, f, r);
    repeat (64 * HALF + 20) @(posedge aclk);
    chk(32'(irq), 32'h0);
    chk(32'(got_frame[31:18]), 32'(f[31:18]));
    axr(`EMGP_OFS_MAN, rd, r);
    chk(rd, {f[31:16], 16'h5A3C});
    axr(`EMGP_OFS_STATUS, rd, r);
    chk(rd, 32'h1 << `EMGP_ST_MDONE);
  endtask : t_mread

  task automatic t_pause;
    logic [31:0] rd;
    logic [1:0]  r;
    int          n, e;
    e = 2 * `EMGP_PAUSE_BIT_TIMES * 16;
    axw(`EMGP_OFS_MASK, 32'h1 << `EMGP_ST_PEXP, r);
    axw(`EMGP_OFS_PAUSE, 32'hABCD0002, r);
    axr(`EMGP_OFS_PAUSE, rd, r);
    chk(rd, 32'h2);
    wsig(0, e + 200, n);
    chk(32'(n > e - 64 && n < e + 64), 32'h1);
    axr(`EMGP_OFS_PAUSE, rd, r);
    chk(rd, 32'h0);
    axr(`EMGP_OFS_STATUS, rd, r);
    chk(rd, 32'h1 << `EMGP_ST_PEXP);
    axr(`EMGP_OFS_STATUS, rd, r);
    chk(rd, 32'h0);
  endtask : t_pause

  task automatic frame(input logic [47:0] da, input logic [15:0] ty, output logic [31:0] res);
    int n;
    for (int i = 0; i < 14; i++)
    begin
      @(posedge aclk);
      rx_valid <= 1'b1;
      rx_sof   <= (i == 0);
      rx_data  <= i < 6 ? da[8 * i +: 8] : i == 12 ? ty[15:8] : i == 13 ? ty[7:0] : 8'(i);
    end
    @(posedge aclk);
    rx_valid <= 1'b0;
    wsig(1, 10, n);
    res = {26'h0, sa_match, hash_match, type_match};
  endtask : frame

  task automatic t_filter;
    logic [31:0] res;
    logic [1:0]  r;
    // only bucket 31 set: the second address folds to 31, the first to 30
    axw(`EMGP_OFS_HASH_LO, 32'h80000000, r);
    axw(`EMGP_OFS_HASH_HI, 32'h00000000, r);
    axw(8'hA0, 32'h67452301, r);
    axw(8'hA4, 32'h0000AB89, r);
    axw(`EMGP_OFS_TYPE_MATCH, 32'h000088F7, r);
    frame(48'hAB8967452301, 16'h88F7, res);
    chk(res, 32'h00000009);
    frame(48'hAB8967452300, 16'hF788, res);
    chk(res, 32'h00000002);
  endtask : t_filter

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_mwrite();
    t_mread();
    t_pause();
    t_filter();
    results();
  end
endmodule : test_emgp_top

`default_nettype wire
